/* hw/pcb_defs.svh */
// Constants for the pulse count backlight programmer.
`ifndef PCB_DEFS_SVH
`define PCB_DEFS_SVH
`define PCB_CLK_PERIOD_NS     50
`define PCB_LATCH_TIMEOUT_US  500
`define PCB_OFF_TIMEOUT_US    500
`define PCB_LATCH_CYCLES      ((`PCB_LATCH_TIMEOUT_US * 1000) / `PCB_CLK_PERIOD_NS)
`define PCB_OFF_CYCLES        ((`PCB_OFF_TIMEOUT_US * 1000) / `PCB_CLK_PERIOD_NS)
`define PCB_ADDR_BASE         6'h10
`define PCB_MAX_COUNT         6'h20
`define PCB_ADDR_ALL          4'h0
`define PCB_ADDR_MAIN         4'h1
`define PCB_ADDR_SUB          4'h2
`define PCB_ADDR_LOW          4'h3
`define PCB_ADDR_RANGE        4'hc
`define PCB_ADDR_INDEP        4'hf
`define PCB_RANGE_20MA_CODE   4'h0
`define PCB_RANGE_30MA_CODE   4'h1
`define PCB_INDEP_CODE        4'h7
`define PCB_REG_RESET         4'h0
`define PCB_LOW_BOTH_OFF_MAX  4'h3
`define PCB_LOW_SUB_MAX       4'h7
`define PCB_LOW_MAIN_MAX      4'hb
`define PCB_CODE_ZERO_CURRENT 4'hf
`define PCB_NUM_SINKS         6
`endif

/* hw/pcb_pkg.sv */
// Types for the pulse count backlight programmer.
package pcb_pkg;
  typedef enum logic [1:0] {
    PCB_PUMP_1X  = 2'b00,
    PCB_PUMP_1P5 = 2'b01,
    PCB_PUMP_2X  = 2'b10
  } pcb_pump_e;
  typedef logic [3:0] pcb_code_t;
  typedef logic [5:0] pcb_sink_t;
endpackage

/* hw/pcb_line_timer.sv */
// Edge counter and latch and off timeouts on the serial enable line.
`timescale 1ns/1ps
`include "pcb_defs.svh"
module pcb_line_timer #(
  parameter int unsigned LATCH_CYCLES = `PCB_LATCH_CYCLES,
  parameter int unsigned OFF_CYCLES   = `PCB_OFF_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       serial_enable_line,
  output logic            latch_pulse,
  output logic [5:0]      latch_count,
  output logic            off_pulse,
  output logic            line_active
);
  import pcb_pkg::*;

  logic        line_q;
  logic [5:0]  edges_q;
  logic [5:0]  edges_d;
  logic [13:0] timer_q;
  logic [13:0] timer_d;
  logic        done_q;
  logic        active_q;
  wire         rise      = serial_enable_line & ~line_q;
  wire         any_edge  = serial_enable_line ^ line_q;
  wire         hi_expire = serial_enable_line & ~done_q & (timer_q == 14'(LATCH_CYCLES - 1));
  wire         lo_expire = ~serial_enable_line & ~done_q & (timer_q == 14'(OFF_CYCLES - 1));
  wire         saturate  = (edges_q == 6'h3f);

  // The timer restarts on each edge, so only a steady level can expire it.
  assign timer_d = any_edge ? 14'h0000 : (done_q ? timer_q : timer_q + 14'h0001);
  // Beyond 63 edges the count sticks, and any count above 32 is discarded later.
  assign edges_d = hi_expire ? 6'h00 : (rise & ~saturate ? edges_q + 6'h01 : edges_q);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_q      <= 1'b0;
      edges_q     <= 6'h00;
      timer_q     <= 14'h0000;
      done_q      <= 1'b1;
      active_q    <= 1'b0;
      latch_pulse <= 1'b0;
      latch_count <= 6'h00;
      off_pulse   <= 1'b0;
    end else begin
      line_q      <= serial_enable_line;
      timer_q     <= timer_d;
      edges_q     <= lo_expire ? 6'h00 : edges_d;
      done_q      <= any_edge ? 1'b0 : (done_q | hi_expire | lo_expire);
      latch_pulse <= hi_expire & (edges_q != 6'h00);
      latch_count <= hi_expire ? edges_q : latch_count;
      off_pulse   <= lo_expire;
      if (rise) begin
        active_q <= 1'b1;
      end else if (lo_expire) begin
        active_q <= 1'b0;
      end
    end
  end
  assign line_active = active_q;
endmodule

/* hw/pcb_pump_ctrl.sv */
// Charge pump mode step controller driven by sink dropout.
`timescale 1ns/1ps
module pcb_pump_ctrl (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              enable,
  input  wire logic              dropout,
  input  wire logic              relax,
  output pcb_pkg::pcb_pump_e     pump_mode
);
  import pcb_pkg::*;

  pcb_pump_e mode_q;
  pcb_pump_e mode_d;
  logic      drop_q;
  // Stepping only on the onset of dropout lets the pump settle before it climbs again.
  wire       step_up = dropout & ~drop_q;

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      PCB_PUMP_1X:  if (step_up) mode_d = PCB_PUMP_1P5;
      PCB_PUMP_1P5: begin
        if (step_up) begin
          mode_d = PCB_PUMP_2X;
        end else if (relax) begin
          mode_d = PCB_PUMP_1X;
        end
      end
      PCB_PUMP_2X:  if (relax & ~dropout) mode_d = PCB_PUMP_1P5;
      default:      mode_d = PCB_PUMP_1X;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_q <= PCB_PUMP_1X;
      drop_q <= 1'b0;
    end else begin
      mode_q <= enable ? mode_d : PCB_PUMP_1X;
      drop_q <= dropout;
    end
  end
  assign pump_mode = mode_q;

  property p_step;
    @(posedge clock) disable iff (rst)
    enable && $rose(dropout) && mode_q == PCB_PUMP_1X |=> mode_q == PCB_PUMP_1P5;
  endproperty
  a_step: assert property (p_step) else $error("pump did not step up from unity");
endmodule

/* hw/pcb_programmer.sv */
// Pulse count register decoder and sink control for a six sink backlight driver.
`timescale 1ns/1ps
`include "pcb_defs.svh"

module pcb_programmer #(
  parameter int unsigned LATCH_CYCLES = `PCB_LATCH_CYCLES,
  parameter int unsigned OFF_CYCLES   = `PCB_OFF_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 serial_enable_line,
  input  wire logic [5:0]           sink_dropout,
  input  wire logic [5:0]           sink_at_rail,
  input  wire logic                 pump_relax,
  output logic [5:0]                led_sink_channels,
  output pcb_pkg::pcb_code_t        main_level_code,
  output pcb_pkg::pcb_code_t        sub_level_code,
  output logic                      range_30ma,
  output logic                      low_current_mode,
  output logic [1:0]                low_current_step,
  output logic                      independent_mode,
  output pcb_pkg::pcb_pump_e        pump_mode,
  output logic                      device_active
);
  import pcb_pkg::*;

  logic        latch_pulse;
  logic [5:0]  latch_count;
  logic        off_pulse;
  logic        line_active;

  pcb_line_timer #(
    .LATCH_CYCLES (LATCH_CYCLES),
    .OFF_CYCLES   (OFF_CYCLES)
  ) u_timer (
    .clock              (clock),
    .rst                (rst),
    .serial_enable_line (serial_enable_line),
    .latch_pulse        (latch_pulse),
    .latch_count        (latch_count),
    .off_pulse          (off_pulse),
    .line_active        (line_active)
  );

  // Stored registers; data codes are kept as count minus one.
  logic [3:0] addr_q;
  logic [3:0] main_q;
  logic [3:0] sub_q;
  logic [3:0] low_q;
  logic       low_en_q;
  logic       range_q;
  logic       indep_q;
  logic [5:0] mask_q;
  logic [5:0] unused_q;
  logic       written_q;

  wire        is_addr  = latch_pulse & (latch_count > `PCB_ADDR_BASE)
                         & (latch_count <= `PCB_MAX_COUNT);
  wire        is_data  = latch_pulse & (latch_count != 6'h00)
                         & (latch_count <= `PCB_ADDR_BASE);
  wire [3:0]  new_addr = 4'(latch_count - `PCB_ADDR_BASE - 6'h01);
  wire [3:0]  code     = 4'(latch_count - 6'h01);

  // Normal map decode.
  wire n_all   = is_data & ~indep_q & (addr_q == `PCB_ADDR_ALL);
  wire n_main  = is_data & ~indep_q & (addr_q == `PCB_ADDR_MAIN);
  wire n_sub   = is_data & ~indep_q & (addr_q == `PCB_ADDR_SUB);
  wire n_low   = is_data & ~indep_q & (addr_q == `PCB_ADDR_LOW);
  wire n_indep = is_data & ~indep_q & (addr_q == `PCB_ADDR_INDEP)
                 & (code == `PCB_INDEP_CODE);
  // Independent map decode; addresses 0 and 15 fall through with no effect.
  wire i_cur   = is_data & indep_q & (addr_q == `PCB_ADDR_MAIN);
  wire i_hi    = is_data & indep_q & (addr_q == `PCB_ADDR_SUB);
  wire i_lo    = is_data & indep_q & (addr_q == `PCB_ADDR_LOW);
  // Range register applies in both maps; other data codes are ignored.
  wire w_range = is_data & (addr_q == `PCB_ADDR_RANGE)
                 & ((code == `PCB_RANGE_20MA_CODE) | (code == `PCB_RANGE_30MA_CODE));

  wire any_cur = n_all | n_main | n_sub | n_low | i_cur;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_q    <= `PCB_REG_RESET;
      main_q    <= `PCB_REG_RESET;
      sub_q     <= `PCB_REG_RESET;
      low_q     <= `PCB_REG_RESET;
      low_en_q  <= 1'b0;
      range_q   <= 1'b0;
      indep_q   <= 1'b0;
      mask_q    <= 6'h3f;
      written_q <= 1'b0;
    end else if (off_pulse) begin
      addr_q    <= `PCB_REG_RESET;
      main_q    <= `PCB_REG_RESET;
      sub_q     <= `PCB_REG_RESET;
      low_q     <= `PCB_REG_RESET;
      low_en_q  <= 1'b0;
      range_q   <= 1'b0;
      indep_q   <= 1'b0;
      mask_q    <= 6'h3f;
      written_q <= 1'b0;
    end else begin
      // Address is only replaced by an address burst, never by data.
      if (is_addr) addr_q <= new_addr;
      if (n_all | i_cur) begin
        main_q <= code;
        sub_q  <= code;
      end
      if (n_main) main_q <= code;
      if (n_sub) sub_q <= code;
      if (n_low) low_q <= code;
      if (any_cur) low_en_q <= n_low;
      if (any_cur) written_q <= 1'b1;
      if (w_range) range_q <= (code == `PCB_RANGE_30MA_CODE);
      if (n_indep) indep_q <= 1'b1;
      if (i_hi) mask_q[5:2] <= code;
      if (i_lo) mask_q[1:0] <= code[3:2];
    end
  end

  // Sinks tied to the rail are dropped while the device is active.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      unused_q <= 6'h00;
    end else if (~line_active) begin
      unused_q <= 6'h00;
    end else begin
      unused_q <= unused_q | sink_at_rail;
    end
  end

  // Low-current groups: codes 0-3 off, 4-7 sub, 8-11 main, 12-15 both.
  wire low_main = low_q > `PCB_LOW_SUB_MAX;
  wire low_sub  = (low_q > `PCB_LOW_BOTH_OFF_MAX) & ~((low_q > `PCB_LOW_SUB_MAX)
                  & (low_q <= `PCB_LOW_MAIN_MAX));
  wire main_on  = low_en_q ? low_main : (main_q != `PCB_CODE_ZERO_CURRENT);
  wire sub_on   = low_en_q ? low_sub  : (sub_q  != `PCB_CODE_ZERO_CURRENT);
  wire [5:0] group_on = {sub_on, {5{main_on}}};
  wire [5:0] sink_d   = (written_q & line_active) ? (group_on & mask_q & ~unused_q)
                                                  : 6'h00;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      led_sink_channels <= 6'h00;
      main_level_code   <= `PCB_REG_RESET;
      sub_level_code    <= `PCB_REG_RESET;
      range_30ma        <= 1'b0;
      low_current_mode  <= 1'b0;
      low_current_step  <= 2'b00;
      independent_mode  <= 1'b0;
      device_active     <= 1'b0;
    end else begin
      led_sink_channels <= sink_d;
      main_level_code   <= main_q;
      sub_level_code    <= sub_q;
      range_30ma        <= range_q;
      low_current_mode  <= low_en_q;
      low_current_step  <= low_q[1:0];
      independent_mode  <= indep_q;
      device_active     <= line_active;
    end
  end

  pcb_pump_ctrl u_pump (
    .clock     (clock),
    .rst       (rst),
    .enable    (|led_sink_channels),
    .dropout   (|(sink_dropout & led_sink_channels)),
    .relax     (pump_relax),
    .pump_mode (pump_mode)
  );

  property p_addr_latch;
    @(posedge clock) disable iff (rst)
    latch_pulse && latch_count == 6'h13 && !off_pulse |=> addr_q == 4'h2;
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address not latched");

  property p_addr_keep;
    @(posedge clock) disable iff (rst)
    is_data && !off_pulse |=> $stable(addr_q);
  endproperty
  a_addr_keep: assert property (p_addr_keep) else $error("address changed by data");

  property p_off_clear;
    @(posedge clock) disable iff (rst)
    off_pulse |=> addr_q == 4'h0 && main_q == 4'h0 && !indep_q && !range_q ##1 sink_d == 6'h00;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("shutdown did not clear");

  property p_all_write;
    @(posedge clock) disable iff (rst)
    n_all && !off_pulse |=> main_q == sub_q && main_q == $past(code);
  endproperty
  a_all_write: assert property (p_all_write) else $error("all sinks not equal");

  property p_big_ignored;
    @(posedge clock) disable iff (rst)
    latch_pulse && latch_count > 6'h20 |=> $stable(addr_q) && $stable(main_q) && $stable(sub_q);
  endproperty
  a_big_ignored: assert property (p_big_ignored) else $error("overlong count used");

  property p_indep_enter;
    @(posedge clock) disable iff (rst)
    n_indep && !off_pulse |=> indep_q ##2 independent_mode;
  endproperty
  a_indep_enter: assert property (p_indep_enter) else $error("independent mode missing");

  property p_range;
    @(posedge clock) disable iff (rst)
    w_range && code == 4'h1 && !off_pulse |=> ##1 range_30ma;
  endproperty
  a_range: assert property (p_range) else $error("range not 30mA");

  property p_rail_off;
    @(posedge clock) disable iff (rst)
    sink_at_rail[0] && line_active |=> ##1 !led_sink_channels[0];
  endproperty
  a_rail_off: assert property (p_rail_off) else $error("unused sink left on");

  property p_indep_hold;
    @(posedge clock) disable iff (rst)
    indep_q && !off_pulse |=> indep_q;
  endproperty
  a_indep_hold: assert property (p_indep_hold) else $error("left independent mode");

  property p_main_write;
    @(posedge clock) disable iff (rst)
    n_main |=> main_q == $past(code);
  endproperty
  a_main_write: assert property (p_main_write) else $error("main level not stored");

  property p_sub_write;
    @(posedge clock) disable iff (rst)
    n_sub |=> sub_q == $past(code);
  endproperty
  a_sub_write: assert property (p_sub_write) else $error("sub level not stored");

  property p_low_write;
    @(posedge clock) disable iff (rst)
    n_low |=> low_en_q && low_q == $past(code);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low current code not stored");

  property p_mask_hi;
    @(posedge clock) disable iff (rst)
    i_hi |=> mask_q[5:2] == $past(code);
  endproperty
  a_mask_hi: assert property (p_mask_hi) else $error("upper sink mask not stored");

  property p_mask_lo;
    @(posedge clock) disable iff (rst)
    i_lo |=> mask_q[1:0] == $past(code[3:2]);
  endproperty
  a_mask_lo: assert property (p_mask_lo) else $error("lower sink mask not stored");

  property p_indep_ignore;
    @(posedge clock) disable iff (rst)
    is_data && indep_q && (addr_q == `PCB_ADDR_ALL || addr_q == `PCB_ADDR_INDEP)
      |=> $stable(main_q) && $stable(sub_q) && $stable(mask_q) && indep_q;
  endproperty
  a_indep_ignore: assert property (p_indep_ignore) else $error("dead address changed state");

  property p_idle_dark;
    @(posedge clock) disable iff (rst)
    !line_active |=> led_sink_channels == 6'h00;
  endproperty
  a_idle_dark: assert property (p_idle_dark) else $error("sink on while shut down");

  property p_zero_code;
    @(posedge clock) disable iff (rst)
    !low_en_q && main_q == `PCB_CODE_ZERO_CURRENT |=> led_sink_channels[4:0] == 5'h00;
  endproperty
  a_zero_code: assert property (p_zero_code) else $error("main sinks on at zero code");

  property p_range_20;
    @(posedge clock) disable iff (rst)
    w_range && code == `PCB_RANGE_20MA_CODE |=> ##1 !range_30ma;
  endproperty
  a_range_20: assert property (p_range_20) else $error("range not 20mA");

  c_addr: cover property (@(posedge clock) is_addr);
  c_data: cover property (@(posedge clock) n_all);
  c_indep: cover property (@(posedge clock) i_hi);
  c_off: cover property (@(posedge clock) off_pulse);
  c_low: cover property (@(posedge clock) n_low);
endmodule

/* bench/pcb_host_model.sv */
// Host controller model that drives the serial enable line with pulse bursts.
`timescale 1ns/1ps
module pcb_host_model #(
  parameter int unsigned LATCH_CYCLES = 20,
  parameter int unsigned OFF_CYCLES   = 30
) (
  input  wire logic clock,
  output logic      serial_enable_line
);
  initial serial_enable_line = 1'b0;

  // Each edge is one low cycle then one high cycle, well inside both timeouts.
  // The burst is then closed by holding the line high past the latch timeout.
  task automatic pulse_count(input int n);
    int k;
    for (k = 0; k < n; k++) begin
      @(negedge clock) serial_enable_line = 1'b0;
      @(negedge clock) serial_enable_line = 1'b1;
    end
    repeat (LATCH_CYCLES + 4) @(negedge clock);
  endtask

  // Apart from reset, holding the line low past the off timeout is the only way out of independent mode.
  task automatic shutdown();
    @(negedge clock) serial_enable_line = 1'b0;
    repeat (OFF_CYCLES + 4) @(negedge clock);
  endtask
endmodule

/* bench/test_pulse_count_backlight_programmer.sv */
// Self-checking bench for the pulse count programmer against an integer model.
`timescale 1ns/1ps
module test_pulse_count_backlight_programmer;
  import pcb_pkg::*;
  localparam int unsigned LAT = 20;
  localparam int unsigned OFF = 30;
  logic               clock;
  logic               rst;
  logic [5:0]         sink_dropout;
  logic [5:0]         sink_at_rail;
  logic               pump_relax;
  wire                serial_enable_line;
  logic [5:0]         led_sink_channels;
  pcb_code_t          main_level_code;
  pcb_code_t          sub_level_code;
  logic               range_30ma;
  logic               low_current_mode;
  logic [1:0]         low_current_step;
  logic               independent_mode;
  logic               device_active;
  pcb_pump_e          pump_mode;
  int                 n_mismatch;
  int                 n_compared;
  int                 seed;
  int                 i;
  int                 m_addr, m_main, m_sub, m_r30, m_lc, m_lstep, m_lmain, m_lsub;
  int                 m_ind, m_on, m_act;
  logic [5:0]         m_mask;
  logic [5:0]         m_rail;

  pcb_programmer #(.LATCH_CYCLES(LAT), .OFF_CYCLES(OFF)) pcb_programmer_i (
    .clock(clock), .rst(rst), .serial_enable_line(serial_enable_line),
    .sink_dropout(sink_dropout), .sink_at_rail(sink_at_rail), .pump_relax(pump_relax),
    .led_sink_channels(led_sink_channels), .main_level_code(main_level_code),
    .sub_level_code(sub_level_code), .range_30ma(range_30ma),
    .low_current_mode(low_current_mode), .low_current_step(low_current_step),
    .independent_mode(independent_mode), .pump_mode(pump_mode),
    .device_active(device_active)
  );

  pcb_host_model #(.LATCH_CYCLES(LAT), .OFF_CYCLES(OFF)) pcb_host_model_i (
    .clock(clock), .serial_enable_line(serial_enable_line)
  );

  always #25 clock = ~clock;

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic model_clear();
    m_addr = 0; m_main = 0; m_sub = 0; m_r30 = 0; m_lc = 0; m_lstep = 0;
    m_lmain = 0; m_lsub = 0; m_ind = 0; m_on = 0; m_act = 0;
    m_mask = 6'h3f;
    m_rail = 6'h00;
  endtask

  task automatic model_write(input int n);
    int d;
    d = n - 1;
    m_act = 1;
    if (n > 32 || n < 1) return;
    if (n > 16) begin
      m_addr = n - 17;
      return;
    end
    if (m_ind == 0 && m_addr == 0) begin
      m_main = d; m_sub = d; m_on = 1; m_lc = 0;
    end else if (m_addr == 1) begin
      m_main = d; m_lc = 0; m_on = 1;
      if (m_ind != 0) m_sub = d;
    end else if (m_addr == 2 && m_ind == 0) begin
      m_sub = d; m_lc = 0; m_on = 1;
    end else if (m_addr == 2) begin
      m_mask[5:2] = d[3:0];
    end else if (m_addr == 3 && m_ind == 0) begin
      m_lc = 1; m_lstep = d % 4; m_lmain = d / 8; m_lsub = (d / 4) % 2;
    end else if (m_addr == 3) begin
      m_mask[1:0] = d[3:2];
    end else if (m_addr == 12 && d < 2) begin
      m_r30 = d;
    end else if (m_addr == 15 && m_ind == 0 && d == 7) begin
      m_ind = 1; m_mask = 6'h3f;
    end
  endtask

  function automatic logic [5:0] exp_led();
    logic [5:0] e;
    if (m_ind != 0) e = (m_on != 0 && m_main != 15) ? m_mask : 6'h00;
    else if (m_lc != 0) e = {m_lsub != 0, {5{m_lmain != 0}}};
    else if (m_on != 0) e = {m_sub != 15, {5{m_main != 15}}};
    else e = 6'h00;
    return e & ~m_rail;
  endfunction

  task automatic check_all();
    check("led", {2'b00, led_sink_channels}, {2'b00, exp_led()});
    check("main", {4'h0, main_level_code}, 8'(m_main));
    check("sub", {4'h0, sub_level_code}, 8'(m_sub));
    check("range", {7'h00, range_30ma}, 8'(m_r30));
    check("low", {7'h00, low_current_mode}, 8'(m_lc));
    if (m_lc != 0) check("step", {6'h00, low_current_step}, 8'(m_lstep));
    check("indep", {7'h00, independent_mode}, 8'(m_ind));
    check("active", {7'h00, device_active}, 8'(m_act));
  endtask

  task automatic wr(input int n);
    model_write(n);
    pcb_host_model_i.pulse_count(n);
    check_all();
  endtask

  // Random codes stay in 1 to 15 so that the data never lands in the address range.
  function automatic int rnd_code();
    return 1 + (($random(seed) & 32'h7fff) % 15);
  endfunction

  initial begin
    #(50 * 20000);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    clock = 1'b0; rst = 1'b1; sink_dropout = 6'h00; sink_at_rail = 6'h00;
    pump_relax = 1'b0; seed = 32'h2c16; n_mismatch = 0; n_compared = 0;
    model_clear();
    repeat (4) @(negedge clock);
    rst = 1'b0;
    check_all();
    wr(rnd_code());
    wr(18); wr(rnd_code()); wr(5);
    wr(19); wr(4);
    wr(29); wr(2); wr(3); wr(1);
    wr(40); wr(22); wr(3);
    wr(20);
    for (i = 1; i <= 16; i++) wr(i);
    wr(17); wr(16); wr(1);
    sink_dropout = 6'h01;
    repeat (4) @(negedge clock);
    check("pump", {6'h00, pump_mode}, {6'h00, PCB_PUMP_1P5});
    sink_dropout = 6'h00;
    repeat (2) @(negedge clock);
    sink_dropout = 6'h02;
    repeat (4) @(negedge clock);
    check("pump", {6'h00, pump_mode}, {6'h00, PCB_PUMP_2X});
    sink_dropout = 6'h00;
    pump_relax = 1'b1;
    repeat (4) @(negedge clock);
    check("pump", {6'h00, pump_mode}, {6'h00, PCB_PUMP_1X});
    pump_relax = 1'b0;
    sink_at_rail = 6'h09;
    m_rail = 6'h09;
    repeat (4) @(negedge clock);
    sink_at_rail = 6'h00;
    repeat (4) @(negedge clock);
    check_all();
    pcb_host_model_i.shutdown();
    model_clear();
    check_all();
    wr(7);
    wr(32); wr(8);
    wr(18); wr(3); wr(19); wr(6); wr(20); wr(9);
    wr(17); wr(16); wr(32); wr(1); wr(29); wr(2);
    pcb_host_model_i.shutdown();
    model_clear();
    check_all();
    end_of_test();
  end
endmodule
